// file: core/scs_pkg.sv
package scs_pkg;

    // Frame layout: address bits, then one command bit, then the data word.
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam int CNT_W = 5;

    // Bit counter value on the rising edge that carries the command bit.
    localparam logic [4:0] CMD_IDX = 5'h09;
    // Bit counter value on the rising edge that carries the last data bit.
    localparam logic [4:0] LAST_IDX = 5'h19;
    // Value of the command bit that requests a write.
    localparam logic CMD_WRITE = 1'b1;

    // Nominal serial clock period and the system clock period.
    localparam int T_SCK_NS = 100;
    localparam int T_SYS_NS = 25;
    // Least gap between two accesses, in serial clock periods.
    localparam int GAP_SCK = 2;
    localparam int T_GAP_NS = GAP_SCK * T_SCK_NS;
    // Least gap counted in system clocks, rounded up.
    localparam int GAP_SYS_CYC = (T_GAP_NS + T_SYS_NS - 1) / T_SYS_NS;

    // Reset values.
    localparam logic [4:0] CNT_RST = 5'h00;
    localparam logic [8:0] ADDR_RST = 9'h000;
    localparam logic [15:0] DATA_RST = 16'h0000;

    typedef enum logic [1:0] {
        SCS_ADDR = 2'b00,
        SCS_WR = 2'b01,
        SCS_RD = 2'b10,
        SCS_DONE = 2'b11
    } scs_state_e;

    typedef struct packed {
        scs_state_e st;
        logic [4:0] cnt;
        logic [8:0] addr;
        logic [15:0] sr;
        logic oe;
    } scs_link_s;

    typedef struct packed {
        logic ref_lvl;
        logic wr_pulse;
        logic [8:0] wr_addr;
        logic [15:0] wr_data;
    } scs_sys_s;

    localparam scs_link_s LINK_RST = '{st: SCS_ADDR, cnt: CNT_RST, addr: ADDR_RST, sr: DATA_RST, oe: 1'b0};
    localparam scs_sys_s SYS_RST = '{ref_lvl: 1'b0, wr_pulse: 1'b0, wr_addr: ADDR_RST, wr_data: DATA_RST};

endpackage

// file: core/scs_regmem.sv
`timescale 1ns/1ps
module scs_regmem #(
    parameter int AW = scs_pkg::ADDR_W,
    parameter int DW = scs_pkg::DATA_W
) (
    input wire logic sck,
    input wire logic arst,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata,
    output logic ev_toggle,
    output logic [AW-1:0] ev_addr,
    output logic [DW-1:0] ev_data
);
    typedef struct packed {
        logic tgl;
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
    } scs_ev_s;

    logic [DW-1:0] mem [0:(1<<AW)-1];
    scs_ev_s q, d;

    // The array lives on the serial clock so a read word is ready within the command bit's edge.
    always_ff @(posedge sck) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];

    // The last written word is held steady until the next write, so the system side may read it
    // after the toggle has crossed; writes are far apart compared with the synchroniser delay.
    always_comb begin
        d = q;
        if (we) begin
            d.tgl = ~q.tgl;
            d.addr = waddr;
            d.data = wdata;
        end
    end

    always_ff @(posedge sck or posedge arst) begin
        if (arst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ev_toggle = q.tgl;
    assign ev_addr = q.addr;
    assign ev_data = q.data;
endmodule

// file: core/scs_spi_slave.sv
`timescale 1ns/1ps
module scs_spi_slave (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso_bit,
    output logic miso_oe,
    output logic cfg_wr_pulse,
    output logic [scs_pkg::ADDR_W-1:0] cfg_wr_addr,
    output logic [scs_pkg::DATA_W-1:0] cfg_wr_data
);
    scs_pkg::scs_link_s lq, ld;
    scs_pkg::scs_sys_s sq, sd;

    logic we;
    logic [scs_pkg::DATA_W-1:0] wdata;
    logic [scs_pkg::DATA_W-1:0] rdata;
    logic ev_toggle;
    logic ev_lvl;
    logic [scs_pkg::ADDR_W-1:0] ev_addr;
    logic [scs_pkg::DATA_W-1:0] ev_data;

    // True on the rising edge that carries the last data bit of a frame.
    function automatic logic last_edge(input logic [4:0] cnt);
        return cnt == scs_pkg::LAST_IDX;
    endfunction

    scs_regmem #(
        .AW(scs_pkg::ADDR_W),
        .DW(scs_pkg::DATA_W)
    ) u_mem (
        .sck(sck),
        .arst(rst),
        .we(we),
        .waddr(lq.addr),
        .wdata(wdata),
        .raddr(lq.addr),
        .rdata(rdata),
        .ev_toggle(ev_toggle),
        .ev_addr(ev_addr),
        .ev_data(ev_data)
    );

    // Link side: every frame bit is taken on a rising sck edge.
    always_comb begin
        ld = lq;
        we = 1'b0;
        wdata = {lq.sr[scs_pkg::DATA_W-2:0], mosi};
        ld.cnt = lq.cnt + 5'h01;
        case (lq.st)
            scs_pkg::SCS_ADDR: begin
                if (lq.cnt != scs_pkg::CMD_IDX) begin
                    // Address arrives most significant bit first.
                    ld.addr = {lq.addr[scs_pkg::ADDR_W-2:0], mosi};
                end else if (mosi == scs_pkg::CMD_WRITE) begin
                    ld.st = scs_pkg::SCS_WR;
                end else begin
                    // The word is loaded and driven before the first falling edge the master samples.
                    ld.st = scs_pkg::SCS_RD;
                    ld.sr = rdata;
                    ld.oe = 1'b1;
                end
            end
            scs_pkg::SCS_WR: begin
                ld.sr = wdata;
                if (last_edge(lq.cnt)) begin
                    we = 1'b1;
                    ld.st = scs_pkg::SCS_DONE;
                end
            end
            scs_pkg::SCS_RD: begin
                ld.sr = {lq.sr[scs_pkg::DATA_W-2:0], 1'b0};
                if (last_edge(lq.cnt)) begin
                    ld.oe = 1'b0;
                    ld.st = scs_pkg::SCS_DONE;
                end
            end
            default: begin
                // Extra clocks after a finished frame are ignored.
                ld.cnt = lq.cnt;
            end
        endcase
    end

    // A high select clears the frame at once, so a cut-short access leaves nothing behind.
    always_ff @(posedge sck or posedge ss_n) begin
        if (ss_n) begin
            lq <= scs_pkg::LINK_RST;
        end else begin
            lq <= ld;
        end
    end

    assign miso_bit = lq.sr[scs_pkg::DATA_W-1];
    assign miso_oe = lq.oe;

    // System side: a write event crosses as a toggle, the held word is taken after it.
    scs_sync3 u_sync (
        .clk(sys_clk),
        .rst(rst),
        .din(ev_toggle),
        .dout(ev_lvl)
    );

    always_comb begin
        sd = sq;
        sd.wr_pulse = 1'b0;
        if (ev_lvl != sq.ref_lvl) begin
            sd.ref_lvl = ev_lvl;
            sd.wr_pulse = 1'b1;
            sd.wr_addr = ev_addr;
            sd.wr_data = ev_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sq <= scs_pkg::SYS_RST;
        end else begin
            sq <= sd;
        end
    end

    assign cfg_wr_pulse = sq.wr_pulse;
    assign cfg_wr_addr = sq.wr_addr;
    assign cfg_wr_data = sq.wr_data;
endmodule

// file: core/scs_sync3.sv
`timescale 1ns/1ps
module scs_sync3 (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } scs_sync_s;

    scs_sync_s q, d;

    // The first stage feeds only the second; the level moves once stages two and three agree.
    always_comb begin
        d = q;
        d.s1 = din;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.lvl = q.s3;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.lvl;
endmodule

// file: testbench/scs_checker.sv
`timescale 1ns/1ps
module scs_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    input wire logic miso_bit,
    input wire logic miso_oe,
    input wire logic cfg_wr_pulse,
    input wire logic [scs_pkg::ADDR_W-1:0] cfg_wr_addr,
    input wire logic [scs_pkg::DATA_W-1:0] cfg_wr_data
);
    logic [4:0] cnt_q;
    // Counts rising sck edges of a frame; select high clears it just as it clears the link logic.
    always_ff @(posedge sck or posedge ss_n) begin
        if (ss_n) begin
            cnt_q <= 5'h00;
        end else if (cnt_q != 5'h1f) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end
    oe_idle_a: assert property (@(posedge sys_clk) disable iff (rst) ss_n |-> !miso_oe)
        else $error("miso driven while not selected");
    pulse_one_a: assert property (@(posedge sys_clk) disable iff (rst) cfg_wr_pulse |=> !cfg_wr_pulse)
        else $error("write pulse longer than one cycle");
    word_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        !cfg_wr_pulse |-> $stable(cfg_wr_addr) && $stable(cfg_wr_data))
        else $error("write word changed without a pulse");
    rst_clear_a: assert property (@(posedge sys_clk)
        rst |=> !cfg_wr_pulse && cfg_wr_addr == 9'h000 && cfg_wr_data == 16'h0000)
        else $error("write outputs not cleared by reset");
    rd_start_a: assert property (@(posedge sck) disable iff (ss_n)
        (cnt_q == 5'h09 && !mosi) |=> miso_oe)
        else $error("read did not drive miso");
    wr_quiet_a: assert property (@(posedge sck) disable iff (ss_n)
        (cnt_q == 5'h09 && mosi) |=> !miso_oe[*8])
        else $error("miso driven during a write");
    oe_window_a: assert property (@(posedge sck) disable iff (ss_n)
        miso_oe |-> cnt_q >= 5'h0a && cnt_q <= 5'h19)
        else $error("miso driven outside read data");
    oe_rise_a: assert property (@(posedge sck) disable iff (ss_n) $rose(miso_oe) |-> cnt_q == 5'h0a)
        else $error("read data started on the wrong edge");
endmodule
bind scs_spi_slave scs_chk chk (.sys_clk(sys_clk), .rst(rst), .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso_bit(miso_bit),
    .miso_oe(miso_oe), .cfg_wr_pulse(cfg_wr_pulse), .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data));

// file: testbench/scs_master.sv
`timescale 1ns/1ps
module scs_master (
    output logic sck,
    output logic ss_n,
    output logic mosi,
    input wire logic miso
);
    // Select rises once every process waits on it, so the link logic, which select resets, starts cleared.
    initial begin
        sck = 1'b0;
        ss_n = 1'b0;
        mosi = 1'b0;
        #5;
        ss_n = 1'b1;
    end
    // Sends n of the 26 frame bits; fewer than 26 cuts the access short. sck stands low between frames.
    task automatic frame(input logic [25:0] bits, input int n, output logic [15:0] rd);
        rd = 16'h0000;
        ss_n = 1'b0;
        mosi = bits[25];
        #32;
        for (int i = 1; i <= n; i++) begin
            sck = 1'b1;
            #16;
            sck = 1'b0;
            if (i >= 10 && i <= 25) rd = {rd[14:0], miso};
            if (i < 26) mosi = bits[25 - i];
            #16;
        end
        #16;
        ss_n = 1'b1;
        mosi = ~mosi;
        #64;
    endtask
endmodule

// file: testbench/sensor_config_spi_slave_bench.sv
`timescale 1ns/1ps
module sensor_config_spi_slave_bench;
    logic sys_clk = 1'b0;
    logic rst = 1'b0;
    logic sck, ss_n, mosi, miso_bit, miso_oe, cfg_wr_pulse;
    logic [8:0] cfg_wr_addr;
    logic [15:0] cfg_wr_data;
    logic [15:0] rd;
    wire logic miso = miso_oe ? miso_bit : 1'bz;
    int n_mismatch = 0;
    int check_count = 0;
    int n_ev = 0;
    int cycles = 0;
    always #12.5 sys_clk = ~sys_clk;
    scs_spi_slave DUT (.sys_clk(sys_clk), .rst(rst), .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso_bit(miso_bit),
        .miso_oe(miso_oe), .cfg_wr_pulse(cfg_wr_pulse), .cfg_wr_addr(cfg_wr_addr), .cfg_wr_data(cfg_wr_data));
    scs_master m (.sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso));
    always @(posedge sys_clk) begin
        cycles++;
        if (cfg_wr_pulse === 1'b1) n_ev++;
        if (cycles == 2000) begin
            n_mismatch++;
            conclude();
        end
    end
    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task access(input logic [8:0] a, input logic cmd, input logic [15:0] d, input int n);
        m.frame({a, cmd, d}, n, rd);
        repeat (10) @(negedge sys_clk);
    endtask
    task t_write_read;
        int e;
        e = n_ev;
        access(9'h1ff, 1'b1, 16'ha5c3, 26);
        access(9'h000, 1'b1, 16'h5a3c, 26);
        chk("events", 16'(e + 2), 16'(n_ev));
        chk("wr_addr", 16'h0000, {7'h00, cfg_wr_addr});
        chk("wr_data", 16'h5a3c, cfg_wr_data);
        access(9'h1ff, 1'b0, 16'h0000, 26);
        chk("rd_hi", 16'ha5c3, rd);
        access(9'h000, 1'b0, 16'h0000, 26);
        chk("rd_lo", 16'h5a3c, rd);
    endtask
    task t_abort;
        int e;
        e = n_ev;
        access(9'h1ff, 1'b1, 16'hffff, 25);
        access(9'h1ff, 1'b0, 16'h0000, 26);
        chk("abort_rd", 16'ha5c3, rd);
        chk("abort_ev", 16'(e), 16'(n_ev));
    endtask
    task t_reset;
        int e;
        @(negedge sys_clk);
        rst = 1'b1;
        repeat (3) @(negedge sys_clk);
        rst = 1'b0;
        repeat (6) @(negedge sys_clk);
        chk("rst_addr", 16'h0000, {7'h00, cfg_wr_addr});
        chk("rst_data", 16'h0000, cfg_wr_data);
        chk("idle_oe", 16'h0000, {15'h0000, miso_oe});
        e = n_ev;
        access(9'h0a5, 1'b1, 16'hc33c, 26);
        chk("rst_ev", 16'(e + 1), 16'(n_ev));
        chk("rst_ev_addr", 16'h00a5, {7'h00, cfg_wr_addr});
        chk("rst_ev_data", 16'hc33c, cfg_wr_data);
    endtask
    task conclude;
        if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Reset rises after time zero so the asynchronous clear of the write toggle sees an edge.
    initial begin
        #1;
        rst = 1'b1;
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        repeat (6) @(negedge sys_clk);
        t_write_read();
        t_abort();
        t_reset();
        conclude();
    end
endmodule
